// >>> tb/rpm_link_model.sv
// Link side model: drives the receive stream and link clock, collects tx.
// Assumes the block samples rx on rising and moves tx on falling edges.
`timescale 1ns/1ns
module rpm_link_model (
    output logic      link_clk,
    output logic      rx_serial,
    input  wire logic tx_serial
);
    initial begin
        link_clk = 1'b0;
        rx_serial = 1'b1;
    end
    // Clock stands still between frames; released data shows the inverse
    task run(input logic [31:0] d, input int n, output logic [31:0] q);
        q = '0;
        #2;
        for (int i = 0; i < n; i++) begin
            rx_serial = d[i];
            #40 link_clk = 1'b1;
            #40 q = {tx_serial, q[31:1]};
            link_clk = 1'b0;
        end
        rx_serial = ~rx_serial;
    endtask
endmodule

// >>> tb/rpm_top_tb.sv
// Bench for rpm_top: bus master tasks, link model and self checks.
// Assumes tx FIFO data, when offered, is the byte held in x.
`timescale 1ns/1ns
module rpm_top_tb;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, link_clk, rx_serial, tx_serial, irq;
    logic rx_byte_valid, tx_byte_take;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, rx_byte, last_rx, x;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, q, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    int fails = 0, n_tests = 0, n_rx = 0, n0, seed = 33;
    logic slot_sync = 0, tx_empty = 1;
    rpm_top u_rpm_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk, .rx_serial,
        .slot_sync, .tx_serial, .rx_byte, .rx_byte_valid,
        .tx_byte(x), .tx_fifo_empty(tx_empty), .tx_byte_take, .irq);
    rpm_link_model u_rpm_link_model (.link_clk, .rx_serial, .tx_serial);
    always #5 aclk = ~aclk;
    always @(posedge aclk) if (rx_byte_valid) begin
        last_rx <= rx_byte;
        n_rx <= n_rx + 1;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task chk(input logic [31:0] e, s, input string nm);
        n_tests++;
        if (e !== s) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) s_axi_bready <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        // Let the one cycle lag of irq settle before anyone looks
        repeat (3) @(posedge aclk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rr = s_axi_rresp;
        chk(e, s_axi_rdata, nm);
    endtask
    task link(input logic [31:0] d, input int n);
        u_rpm_link_model.run(d, n, q);
        repeat (10) @(posedge aclk);
    endtask
    function logic found(input logic [31:0] v, input logic [7:0] e);
        found = 1'b0;
        for (int i = 16; i < 25; i++) if (v[i+:8] == e) found = 1'b1;
    endfunction
    task final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (5) @(posedge aclk);
        rd(rpm_pkg::OFS_IDLE_CHAR, 32'h0000_00ff, "idle");
        rd(rpm_pkg::OFS_CMP_CTRL, 32'h0000_0007, "ctrl");
        rd(8'h1c, 32'h0000_0000, "hole");
        chk(rpm_pkg::RESP_SLVERR, rr, "resp");
        x = $random(seed) & 8'hfe;
        wr(rpm_pkg::OFS_IDLE_CHAR, x);
        wr(rpm_pkg::OFS_CMP_CTRL, 32'h0000_0020);
        wr(rpm_pkg::OFS_LINK_CTRL, 32'h0000_0004);
        link(0, 32);
        chk(1, found(q, x), "tx idle");
        wr(rpm_pkg::OFS_CMP_CTRL, 0);
        link(0, 32);
        chk(8'hff, q[31:24], "tx ones");
        tx_empty <= 1'b0;
        link(0, 32);
        chk(1, found(q, x), "tx data");
        tx_empty <= 1'b1;
        $display("test tx done");
        wr(rpm_pkg::OFS_IRQ_EN, 1);
        wr(rpm_pkg::OFS_LINK_CTRL, 1);
        x = $random(seed);
        link(x, 8);
        chk(x, last_rx, "rx");
        rd(rpm_pkg::OFS_CMP_CTRL, 32'h0000_0008, "hit");
        chk(1, irq, "irq");
        rd(rpm_pkg::OFS_IRQ_STAT, 32'h0000_0007, "stat");
        wr(rpm_pkg::OFS_IRQ_EN, 0);
        chk(0, irq, "irq mask");
        wr(rpm_pkg::OFS_IRQ_CLR, 7);
        wr(rpm_pkg::OFS_IRQ_EN, 1);
        chk(0, irq, "irq clr");
        $display("test rx plain done");
        wr(rpm_pkg::OFS_LINK_CTRL, 0);
        wr(rpm_pkg::OFS_CMP_CTRL, 32'h0000_0020);
        wr(rpm_pkg::OFS_LINK_CTRL, 1);
        n0 = n_rx;
        link({x, 8'h7e, 3'h7}, 19);
        chk(n0 + 2, n_rx, "count");
        chk(x, last_rx, "rx hunt");
        rd(rpm_pkg::OFS_CMP_CTRL, 32'h0000_002a, "slide");
        wr(rpm_pkg::OFS_LINK_CTRL, 0);
        wr(rpm_pkg::OFS_CMP_CTRL, 32'h0000_0030);
        wr(rpm_pkg::OFS_LINK_CTRL, 1);
        link({8'h7e, 3'h7}, 11);
        rd(rpm_pkg::OFS_CMP_CTRL, 32'h0000_0037, "miss");
        link({8'h7e, 5'h1f}, 13);
        rd(rpm_pkg::OFS_CMP_CTRL, 32'h0000_003f, "octet");
        wr(rpm_pkg::OFS_LINK_CTRL, 0);
        wr(rpm_pkg::OFS_LINK_CTRL, 3);
        link(0, 3);
        slot_sync <= 1'b1;
        repeat (9) @(posedge aclk);
        slot_sync <= 1'b0;
        link(8'h7e, 8);
        rd(rpm_pkg::OFS_CMP_CTRL, 32'h0000_003f, "slot");
        $display("test rx hunt done");
        final_report;
    end
    // Whole run needs about 15 us; allow a wide margin
    initial begin
        #200_000;
        fails++;
        final_report;
    end
endmodule

// >>> verilog/rpm_hunt.sv
// Sliding receive window and match comparator.
// Assumes shift_en pulses once per received bit; bits arrive LSB first.
`timescale 1ns/1ns
module rpm_hunt #(
    parameter int W = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         restart,
    input  wire logic         shift_en,
    input  wire logic         bit_in,
    input  wire logic [W-1:0] match_char,
    output logic      [W-1:0] win_next,
    output logic              full_next,
    output logic              eq_next
);
    if (W < 2 || W > 15) begin : g_bad_w
        $error("rpm_hunt: W out of range");
    end

    logic [W-1:0] window;
    logic [3:0]   fill;

    always_comb begin
        win_next  = {bit_in, window[W-1:1]};
        full_next = (fill >= 4'(W - 1));
        eq_next   = (win_next == match_char);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            window <= '0;
            fill   <= '0;
        end else if (shift_en) begin
            window <= win_next;
            if (fill < 4'(W)) begin
                fill <= fill + 4'h1;
            end
        end
    end
endmodule

// >>> verilog/rpm_pkg.sv
// Constants and carrier types for the receive match gate and transmit idle
// fill block. Assumes a 32-bit AXI4-Lite register bus on aclk.
package rpm_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_LINK_CTRL  = 8'h00;
    localparam logic [7:0] OFS_CMP_CTRL   = 8'h04;
    localparam logic [7:0] OFS_CMP_CHAR   = 8'h08;
    localparam logic [7:0] OFS_IDLE_CHAR  = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN     = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR    = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LC_RX_EN      = 0;
    localparam int LC_HWY_EN     = 1;
    localparam int LC_TX_EN      = 2;
    localparam int CC_MATCH_EN   = 5;
    localparam int CC_ALIGNED    = 4;
    localparam int CC_HIT        = 3;
    localparam int IRQ_HIT       = 0;
    localparam int IRQ_RX_BYTE   = 1;
    localparam int IRQ_TX_IDLE   = 2;
    localparam int IRQ_W         = 3;

    // ------------------------------------------------------------------
    // Reset values and fixed codes
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CMP_CHAR  = 8'h7E;
    localparam logic [7:0] RST_IDLE_CHAR = 8'hFF;
    localparam logic [7:0] ONES_IDLE     = 8'hFF;
    localparam logic [2:0] OFFSET_NONE   = 3'h7;
    localparam logic [2:0] OFFSET_ZERO   = 3'h0;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
    localparam int         SYNC_STAGES   = 3;

    // Configuration carried from the register file to the link logic
    typedef struct packed {
        logic receiver_enable_bit;
        logic tdm_highway_enable;
        logic tx_enable;
        logic match_enable;
        logic octet_aligned_search;
    } rpm_cfg_t;

endpackage

// >>> verilog/rpm_sync.sv
// Three-stage synchroniser for one level from outside the aclk domain.
// Assumes the source is slow against aclk; a change is passed on only
// once the second and third stages agree.
`timescale 1ns/1ns
module rpm_sync (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic [rpm_pkg::SYNC_STAGES-1:0] stage;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage    <= '0;
            sync_out <= 1'b0;
        end else begin
            stage <= {stage[rpm_pkg::SYNC_STAGES-2:0], async_in};
            // Stage 0 is read only by stage 1
            if (stage[1] == stage[2]) begin
                sync_out <= stage[2];
            end
        end
    end
endmodule

// >>> verilog/rpm_top.sv
// Receive pattern-compare gate and transmit idle-fill selection.
// Assumes serial link signals arrive asynchronously and the receive and
// transmit FIFOs sit on aclk.
// Operation
// - Set hit flag when match character seen; offset field then valid.
// - Compare disabled: hit flag sets on first bit, offset reads 000.
// - Aligned search set: compare only at octet boundaries.
// - Aligned search clear: compare after every bit, sliding window.
// - Compare enabled: nothing enters receive FIFO before the match.
// - Compare disabled: matched byte and all later bytes load directly.
// - Compare enabled, transmit FIFO empty: send programmed idle char.
// - Idle character register resets to FF, fully writable.
// - Compare disabled, transmit FIFO empty: send FF idle.
// - Offset field holds offset minus one; none reads 111.
// - Octet boundary from slot sync in highway mode, else from enable.
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
module rpm_top #(
    parameter int DW = 8
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [7:0]    s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [7:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic          link_clk,
    input  wire logic          rx_serial,
    input  wire logic          slot_sync,
    output logic               tx_serial,
    output logic [DW-1:0]      rx_byte,
    output logic               rx_byte_valid,
    input  wire logic [DW-1:0] tx_byte,
    input  wire logic          tx_fifo_empty,
    output logic               tx_byte_take,
    output logic               irq
);
    generate
        if (DW != 8) begin : g_bad_width
            $error("rpm_top supports 8-bit characters only");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Registers and link synchronisers
    // ------------------------------------------------------------------
    rpm_pkg::rpm_cfg_t             cfg;
    logic [DW-1:0]                 cmp_char;
    logic [DW-1:0]                 idle_char;
    logic                          hit;
    logic [2:0]                    offset;
    logic [rpm_pkg::IRQ_W-1:0]     irq_stat;
    logic [rpm_pkg::IRQ_W-1:0]     irq_en;
    logic [rpm_pkg::IRQ_W-1:0]     irq_set;
    logic [rpm_pkg::IRQ_W-1:0]     irq_clr;
    logic                          lclk_s;
    logic                          lclk_d;
    logic                          rx_s;
    logic                          sync_s;
    logic                          sync_d;
    logic                          lrise;
    logic                          lfall;
    logic                          rx_en_d;

    rpm_sync u_sync_clk (.aclk(aclk), .aresetn(aresetn),
                         .async_in(link_clk), .sync_out(lclk_s));
    rpm_sync u_sync_rx  (.aclk(aclk), .aresetn(aresetn),
                         .async_in(rx_serial), .sync_out(rx_s));
    rpm_sync u_sync_fs  (.aclk(aclk), .aresetn(aresetn),
                         .async_in(slot_sync), .sync_out(sync_s));

    assign lrise = lclk_s & ~lclk_d;
    assign lfall = ~lclk_s & lclk_d;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lclk_d  <= 1'b0;
            sync_d  <= 1'b0;
            rx_en_d <= 1'b0;
        end else begin
            lclk_d  <= lclk_s;
            sync_d  <= sync_s;
            rx_en_d <= cfg.receiver_enable_bit;
        end
    end

    // ------------------------------------------------------------------
    // Receive side: octet position, hunt and gate
    // ------------------------------------------------------------------
    logic          rx_restart;
    logic          shift_en;
    logic          sync_pend;
    logic [2:0]    pos;
    logic [2:0]    pos_new;
    logic [2:0]    dcnt;
    logic [DW-1:0] win_next;
    logic          full_next;
    logic          eq_next;
    logic          hit_now;
    logic          emit;

    // Disabling the receiver re-arms the hunt; enabling starts octet count
    assign rx_restart = !cfg.receiver_enable_bit;
    assign shift_en   = lrise && cfg.receiver_enable_bit;

    rpm_hunt #(.W(DW)) u_hunt (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .restart    (rx_restart),
        .shift_en   (shift_en),
        .bit_in     (rx_s),
        .match_char (cmp_char),
        .win_next   (win_next),
        .full_next  (full_next),
        .eq_next    (eq_next)
    );

    always_comb begin
        pos_new = (sync_pend ? 3'h0 : pos) + 3'h1;
        hit_now = 1'b0;
        if (!hit) begin
            if (!cfg.match_enable) begin
                hit_now = 1'b1;
            end else if (full_next && eq_next) begin
                // Aligned search only looks where an octet just closed
                hit_now = !cfg.octet_aligned_search
                          || (pos_new == 3'h0);
            end
        end
        if (cfg.match_enable) begin
            emit = hit_now || (hit && dcnt == 3'h7);
        end else begin
            emit = (hit || hit_now) && full_next
                   && (pos_new == 3'h0);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || rx_restart) begin
            pos       <= 3'h0;
            sync_pend <= 1'b0;
        end else begin
            if (shift_en) begin
                pos <= pos_new;
            end
            if (sync_s && !sync_d && cfg.tdm_highway_enable) begin
                sync_pend <= 1'b1;
            end else if (shift_en) begin
                sync_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || rx_restart) begin
            hit    <= 1'b0;
            offset <= rpm_pkg::OFFSET_NONE;
            dcnt   <= 3'h0;
        end else if (shift_en) begin
            if (hit_now) begin
                hit    <= 1'b1;
                offset <= cfg.match_enable ? pos_new - 3'h1
                                           : rpm_pkg::OFFSET_ZERO;
                dcnt   <= 3'h0;
            end else if (hit) begin
                dcnt <= dcnt + 3'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_byte       <= '0;
            rx_byte_valid <= 1'b0;
        end else begin
            rx_byte_valid <= shift_en && emit;
            if (shift_en && emit) begin
                rx_byte <= win_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit side: serialiser with idle fill
    // ------------------------------------------------------------------
    logic [2:0]    tx_cnt;
    logic [DW-1:0] tx_shift;
    logic [DW-1:0] tx_load;
    logic          tx_idle;

    always_comb begin
        tx_idle = tx_fifo_empty;
        if (!tx_fifo_empty) begin
            tx_load = tx_byte;
        end else if (cfg.match_enable) begin
            tx_load = idle_char;
        end else begin
            tx_load = rpm_pkg::ONES_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_cnt       <= 3'h0;
            tx_shift     <= '1;
            tx_serial    <= 1'b1;
            tx_byte_take <= 1'b0;
        end else begin
            tx_byte_take <= 1'b0;
            if (!cfg.tx_enable) begin
                // Line rests at mark while the transmitter is off
                tx_cnt    <= 3'h0;
                tx_serial <= 1'b1;
            end else if (lfall) begin
                tx_cnt <= tx_cnt + 3'h1;
                if (tx_cnt == 3'h0) begin
                    tx_serial    <= tx_load[0];
                    tx_shift     <= {1'b1, tx_load[DW-1:1]};
                    tx_byte_take <= !tx_fifo_empty;
                end else begin
                    tx_serial <= tx_shift[0];
                    tx_shift  <= {1'b1, tx_shift[DW-1:1]};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    assign irq_set = {lfall && cfg.tx_enable && tx_cnt == 3'h0 && tx_idle,
                      shift_en && emit,
                      shift_en && hit_now};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= '0;
            irq      <= 1'b0;
        end else begin
            // A new event wins over a clear in the same cycle
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            irq      <= |(irq_stat & irq_en);
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    logic        aw_full;
    logic        w_full;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        w_lane0;
    logic        do_write;
    logic        next_aw_full;
    logic        next_w_full;
    logic        next_rvalid;
    logic        wr_hit;
    logic [31:0] rd_word;
    logic        rd_hit;

    always_comb begin
        do_write     = aw_full && w_full && !s_axi_bvalid;
        next_aw_full = aw_full ? !do_write : (s_axi_awvalid && s_axi_awready);
        next_w_full  = w_full ? !do_write : (s_axi_wvalid && s_axi_wready);
        next_rvalid  = s_axi_rvalid ? !s_axi_rready
                                    : (s_axi_arvalid && s_axi_arready);
        wr_hit = (aw_addr == rpm_pkg::OFS_LINK_CTRL)
                 || (aw_addr == rpm_pkg::OFS_CMP_CTRL)
                 || (aw_addr == rpm_pkg::OFS_CMP_CHAR)
                 || (aw_addr == rpm_pkg::OFS_IDLE_CHAR)
                 || (aw_addr == rpm_pkg::OFS_IRQ_EN)
                 || (aw_addr == rpm_pkg::OFS_IRQ_CLR);
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (s_axi_araddr == rpm_pkg::OFS_LINK_CTRL) begin
            rd_word[2:0] = {cfg.tx_enable, cfg.tdm_highway_enable,
                            cfg.receiver_enable_bit};
        end else if (s_axi_araddr == rpm_pkg::OFS_CMP_CTRL) begin
            rd_word[5:0] = {cfg.match_enable, cfg.octet_aligned_search,
                            hit, offset};
        end else if (s_axi_araddr == rpm_pkg::OFS_CMP_CHAR) begin
            rd_word[7:0] = cmp_char;
        end else if (s_axi_araddr == rpm_pkg::OFS_IDLE_CHAR) begin
            rd_word[7:0] = idle_char;
        end else if (s_axi_araddr == rpm_pkg::OFS_IRQ_STAT) begin
            rd_word[rpm_pkg::IRQ_W-1:0] = irq_stat;
        end else if (s_axi_araddr == rpm_pkg::OFS_IRQ_EN) begin
            rd_word[rpm_pkg::IRQ_W-1:0] = irq_en;
        end else if (s_axi_araddr == rpm_pkg::OFS_IRQ_CLR) begin
            rd_word = 32'h0000_0000;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_lane0       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= rpm_pkg::RESP_OKAY;
        end else begin
            aw_full       <= next_aw_full;
            w_full        <= next_w_full;
            s_axi_awready <= !next_aw_full;
            s_axi_wready  <= !next_w_full;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data  <= s_axi_wdata;
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? rpm_pkg::RESP_OKAY
                                       : rpm_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg       <= '0;
            cmp_char  <= rpm_pkg::RST_CMP_CHAR;
            idle_char <= rpm_pkg::RST_IDLE_CHAR;
            irq_en    <= '0;
            irq_clr   <= '0;
        end else begin
            irq_clr <= '0;
            if (do_write && w_lane0) begin
                if (aw_addr == rpm_pkg::OFS_LINK_CTRL) begin
                    cfg.receiver_enable_bit <= w_data[rpm_pkg::LC_RX_EN];
                    cfg.tdm_highway_enable  <= w_data[rpm_pkg::LC_HWY_EN];
                    cfg.tx_enable           <= w_data[rpm_pkg::LC_TX_EN];
                end else if (aw_addr == rpm_pkg::OFS_CMP_CTRL) begin
                    cfg.match_enable <= w_data[rpm_pkg::CC_MATCH_EN];
                    cfg.octet_aligned_search <= w_data[rpm_pkg::CC_ALIGNED];
                end else if (aw_addr == rpm_pkg::OFS_CMP_CHAR) begin
                    cmp_char <= w_data[DW-1:0];
                end else if (aw_addr == rpm_pkg::OFS_IDLE_CHAR) begin
                    idle_char <= w_data[DW-1:0];
                end else if (aw_addr == rpm_pkg::OFS_IRQ_EN) begin
                    irq_en <= w_data[rpm_pkg::IRQ_W-1:0];
                end else if (aw_addr == rpm_pkg::OFS_IRQ_CLR) begin
                    irq_clr <= w_data[rpm_pkg::IRQ_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= rpm_pkg::RESP_OKAY;
        end else begin
            s_axi_rvalid  <= next_rvalid;
            s_axi_arready <= !next_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? rpm_pkg::RESP_OKAY
                                      : rpm_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_hit_nocmp_zero: assert property (shift_en && hit_now
        && !cfg.match_enable |=> hit && offset == 3'h0)
        else $error("hit without compare did not read offset zero");
    a_hit_needs_char: assert property (shift_en && hit_now
        && cfg.match_enable |-> win_next == cmp_char)
        else $error("hit flagged without matching character");
    a_aligned_offset: assert property ($rose(hit)
        && cfg.match_enable && cfg.octet_aligned_search |-> offset == 3'h7)
        else $error("aligned search hit off an octet boundary");
    a_sliding_first: assert property (shift_en && !hit
        && full_next && eq_next && cfg.match_enable
        && !cfg.octet_aligned_search |=> hit)
        else $error("sliding search missed a match");
    a_gate_before_hit: assert property (rx_byte_valid
        && cfg.match_enable |-> hit)
        else $error("byte loaded before match in compare mode");
    a_direct_load: assert property (shift_en && hit
        && !cfg.match_enable && pos_new == 3'h0 |=> rx_byte_valid)
        else $error("octet not loaded with compare disabled");
    a_idle_prog: assert property (lfall && cfg.tx_enable
        && tx_cnt == 3'h0 && tx_fifo_empty && cfg.match_enable
        |=> tx_serial == $past(idle_char[0])
            ##0 tx_shift[6:0] == $past(idle_char[7:1]))
        else $error("programmed idle character not sent");
    a_idle_reset: assert property ($past(aresetn) == 1'b0
        |-> idle_char == 8'hFF)
        else $error("idle character not FF after reset");
    a_idle_ones: assert property (lfall && cfg.tx_enable
        && tx_cnt == 3'h0 && tx_fifo_empty && !cfg.match_enable
        |=> tx_serial && tx_shift == 8'hFF)
        else $error("ones idle not sent with compare disabled");
    a_offset_code: assert property (shift_en && hit_now
        && cfg.match_enable && pos_new == 3'h3
        |=> offset == 3'h2)
        else $error("offset not encoded as offset minus one");
    a_slot_boundary: assert property (shift_en && sync_pend
        |=> pos == 3'h1)
        else $error("octet count not restarted at slot boundary");
    a_enable_boundary: assert property (cfg.receiver_enable_bit
        && !rx_en_d |-> pos == 3'h0)
        else $error("octet count not restarted at receiver enable");

    c_match_hit:  cover property ($rose(hit) && cfg.match_enable);
    c_auto_hit:   cover property ($rose(hit) && !cfg.match_enable);
    c_rx_byte:    cover property (rx_byte_valid ##[1:100] rx_byte_valid);
    c_tx_idle:    cover property (irq_set[rpm_pkg::IRQ_TX_IDLE]
                                  && cfg.match_enable);
endmodule
